//--- rtl/adc_seq_pkg.sv
package adc_seq_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS  = 20;
	localparam int US_NS          = 1000;
	localparam int CYC_PER_US     = US_NS / CLK_PERIOD_NS;
	// Settling after the reset pulse falls, least time rounds up
	localparam int SETTLE_NS      = 25000;
	localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest response times (busy, bus enable), rounded down, at least one cycle
	localparam int BUSY_RISE_NS   = 15;
	localparam int BUS_EN_NS      = 12;
	localparam int RESP_CYC       = (BUS_EN_NS / CLK_PERIOD_NS < 1) ? 1 :
	                                BUS_EN_NS / CLK_PERIOD_NS;
	// Conversion length in microseconds is (2^(ratio_code+2) - 1): 3,7,...,255
	localparam int CONV_SHIFT_OFS = 2;
	localparam logic [2:0] OS_CODE_MAX = 3'h6;
	// Data path
	localparam int NUM_CH         = 6;
	localparam int WORD_W         = 16;
	localparam int FIFO_DEPTH     = 16;
	localparam int CONV_CNT_W     = 20;

	typedef struct packed {
		logic              first;   // Word belongs to the first channel
		logic [WORD_W-1:0] data;    // Conversion result
	} word_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_PUSH = 2'h3
	} conv_state_t;
endpackage : adc_seq_pkg

//--- rtl/word_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,       // Block clock
	input  wire logic             rst_n,     // Synchronised reset, active low
	input  wire logic             clr,       // Drop all content
	input  wire logic             in_valid,  // Write side offers a word
	output logic                  in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Word to store
	output logic                  out_valid, // A word is waiting
	input  wire logic             out_ready, // Read side takes the word
	output logic      [WIDTH-1:0] out_data   // Oldest word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Full and empty come straight from the fill count
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage, written only on an accepted push
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and count; wrap relies on power-of-two depth
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clr) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : word_fifo
`default_nettype wire

//--- rtl/adc_convert_read_wake_seq.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: Host waits 50 ms (internal) or 13 ms (external reference) before reset.
// R2: Host holds reset high at least 50 ns.
// R3: Host waits 25 us after reset falls before any convert start.
// R4: Busy stays high 3..255 us following oversampling ratio 1..64.
// R5: Host spaces conversion cycles 4, 5.6 or 8 us by read style.
// R6: Busy rises within 15 ns after the later convert-start rising edge.
// R7: Data bus leaves high impedance on select fall, floats on select rise.
// R8: Each read strobe fall presents the next word within 17 ns.
// R9: Tied strobes: fall drives the flag, rise floats the bus.
// R10: Separate strobes: select fall drives the flag low before reads.
// R11: Separate strobes: each read fall updates the flag level.
// R12: Flag floats within 10 ns of select rising.
// R13: Words come in channel order; flag high only for the first channel.
module adc_convert_read_wake_seq
	import adc_seq_pkg::*;
#(
	parameter int CONV_UNIT_CYC = adc_seq_pkg::CYC_PER_US
) (
	input  wire logic                          ref_clk,           // 50 MHz clock
	input  wire logic                          nrst,              // Async reset, active low
	input  wire logic                          standby_control_n, // Low holds the part asleep
	input  wire logic                          reset_pulse,       // Host reset, active high
	input  wire logic [2:0]                    os_ratio,          // Oversampling code 0..6
	input  wire logic                          convert_start_a,   // Convert start, first group
	input  wire logic                          convert_start_b,   // Convert start, second group
	input  wire logic                          strobes_tied,      // Select and read tied
	input  wire logic                          cs_n,              // Chip select, active low
	input  wire logic                          rd_n,              // Read strobe, active low
	input  wire logic [adc_seq_pkg::NUM_CH*adc_seq_pkg::WORD_W-1:0] channel_words, // Core results
	output logic                               busy,              // Conversion in progress
	output logic [adc_seq_pkg::WORD_W-1:0]     parallel_data_bus, // Data bus value
	output logic                               parallel_data_bus_oe, // Data bus driven
	output logic                               first_word_flag,   // First-word flag value
	output logic                               first_word_flag_oe // Flag driven
);
	import adc_seq_pkg::*;

	logic                  rst_meta_q;
	logic                  rst_n;
	conv_state_t           state_q;
	logic [CONV_CNT_W-1:0] conv_cnt_q;
	logic [13:0]           settle_q;
	logic                  cva_prev_q;
	logic                  cvb_prev_q;
	logic                  arm_a_q;
	logic                  arm_b_q;
	logic                  cs_prev_q;
	logic                  rd_prev_q;
	logic [2:0]            ch_q;
	logic                  busy_q;
	logic [WORD_W-1:0]     bus_q;
	logic                  bus_oe_q;
	logic                  flag_q;
	logic                  flag_oe_q;
	logic                  allow_conv;
	logic                  start_conv;
	logic                  cs_fall;
	logic                  cs_rise;
	logic                  rd_fall;
	logic                  pop;
	logic [2:0]            os_eff;
	logic [CONV_CNT_W-1:0] conv_len;
	word_t                 push_word;
	word_t                 head_word;
	logic                  push_ready;
	logic                  head_valid;

	// Reset release through two flip-flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Edge history of the host strobes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cva_prev_q <= 1'b0;
			cvb_prev_q <= 1'b0;
			cs_prev_q  <= 1'b1;
			rd_prev_q  <= 1'b1;
		end else begin
			cva_prev_q <= convert_start_a;
			cvb_prev_q <= convert_start_b;
			cs_prev_q  <= cs_n;
			rd_prev_q  <= rd_n;
		end
	end

	assign cs_fall = cs_prev_q && !cs_n;
	assign cs_rise = !cs_prev_q && cs_n;
	assign rd_fall = rd_prev_q && !rd_n && !cs_n;

	// Settle counter after the host reset; starts inside it are ignored, not queued
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_q <= '0;
		end else if (reset_pulse || !standby_control_n) begin
			settle_q <= 14'(SETTLE_CYC); // R3
		end else if (settle_q != '0) begin
			settle_q <= settle_q - 14'h1;
		end
	end

	assign allow_conv = standby_control_n && !reset_pulse && (settle_q == '0)
	                    && (state_q == ST_IDLE); // R1 R2 R3

	// Each input arms on its own rising edge; the later edge launches the conversion
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arm_a_q <= 1'b0;
			arm_b_q <= 1'b0;
		end else if (!allow_conv || start_conv) begin
			arm_a_q <= 1'b0;
			arm_b_q <= 1'b0;
		end else begin
			if (convert_start_a && !cva_prev_q) begin
				arm_a_q <= 1'b1;
			end
			if (convert_start_b && !cvb_prev_q) begin
				arm_b_q <= 1'b1;
			end
		end
	end

	assign start_conv = allow_conv
	                    && (arm_a_q || (convert_start_a && !cva_prev_q))
	                    && (arm_b_q || (convert_start_b && !cvb_prev_q)); // R6

	// Codes above the largest ratio fall back to the largest one
	assign os_eff   = (os_ratio > OS_CODE_MAX) ? OS_CODE_MAX : os_ratio;
	assign conv_len = CONV_CNT_W'((((1 << (32'(os_eff) + CONV_SHIFT_OFS)) - 1)
	                  * CONV_UNIT_CYC) - 1);

	// Sequencer: busy for the ratio's time, then load all channels into the buffer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= ST_IDLE;
			conv_cnt_q <= '0;
			ch_q       <= '0;
			busy_q     <= 1'b0;
		end else if (reset_pulse) begin
			state_q    <= ST_IDLE;
			conv_cnt_q <= '0;
			ch_q       <= '0;
			busy_q     <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_conv) begin
						state_q    <= ST_CONV;
						conv_cnt_q <= conv_len; // R4
						busy_q     <= 1'b1;     // R6
					end
				end
				ST_CONV: begin
					if (conv_cnt_q == '0) begin
						state_q <= ST_PUSH;
						ch_q    <= '0;
						busy_q  <= 1'b0;        // R4
					end else begin
						conv_cnt_q <= conv_cnt_q - 1'b1;
					end
				end
				ST_PUSH: begin
					// Stalls here while the buffer is full, so no word is dropped
					if (push_ready) begin
						if (ch_q == 3'(NUM_CH - 1)) begin
							state_q <= ST_IDLE;
						end
						ch_q <= ch_q + 3'h1;    // R13
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign push_word.first = (ch_q == 3'h0); // R13
	assign push_word.data  = channel_words[32'(ch_q)*WORD_W +: WORD_W];
	assign pop             = rd_fall && head_valid;

	word_fifo #(
		.WIDTH ($bits(word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.clr       (reset_pulse),
		.in_valid  (state_q == ST_PUSH),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head_word)
	);

	// Bus enable follows select one cycle later
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_oe_q  <= 1'b0;
			flag_oe_q <= 1'b0;
		end else if (cs_rise || cs_n) begin
			bus_oe_q  <= 1'b0; // R7 R9
			flag_oe_q <= 1'b0; // R12
		end else if (cs_fall) begin
			bus_oe_q  <= 1'b1; // R7
			flag_oe_q <= 1'b1; // R9 R10
		end
	end

	// Word and flag update; a read strobe outranks the select edge in separate mode
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q  <= '0;
			flag_q <= 1'b0;
		end else if (rd_fall) begin
			if (head_valid) begin
				bus_q  <= head_word.data;  // R8 R13
				flag_q <= head_word.first; // R9 R11 R13
			end else begin
				flag_q <= 1'b0;            // Empty read leaves the old word
			end
		end else if (cs_fall && !strobes_tied) begin
			flag_q <= 1'b0;                // R10
		end
	end

	assign busy                 = busy_q;
	assign parallel_data_bus    = bus_q;
	assign parallel_data_bus_oe = bus_oe_q;
	assign first_word_flag      = flag_q;
	assign first_word_flag_oe   = flag_oe_q;
endmodule : adc_convert_read_wake_seq
`default_nettype wire

//--- sim/adc_seq_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Port checks on busy, data bus and flag timing
module adc_seq_monitor
	import adc_seq_pkg::*;
#(
	parameter int CONV_UNIT_CYC = 50
) (
	input wire logic              ref_clk,              // Clock
	input wire logic              nrst,                 // Reset, active low
	input wire logic              convert_start_a,      // Start a
	input wire logic              convert_start_b,      // Start b
	input wire logic              strobes_tied,         // Tied strobes
	input wire logic              cs_n,                 // Select
	input wire logic              rd_n,                 // Read
	input wire logic              busy,                 // Busy
	input wire logic [WORD_W-1:0] parallel_data_bus,    // Bus
	input wire logic              parallel_data_bus_oe, // Bus enable
	input wire logic              first_word_flag,      // Flag
	input wire logic              first_word_flag_oe    // Flag enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	busy_start_a: assert property ($rose(busy) |-> $past(convert_start_a) && $past(convert_start_b))
		else $error("busy rose without both starts");
	bus_drive_a: assert property ($fell(cs_n) |=> parallel_data_bus_oe)
		else $error("bus not driven after select");
	bus_float_a: assert property ($rose(cs_n) |=> !parallel_data_bus_oe)
		else $error("bus still driven after select");
	flag_float_a: assert property ($rose(cs_n) |=> !first_word_flag_oe)
		else $error("flag still driven after select");
	flag_low_a: assert property ($fell(cs_n) && !strobes_tied |=> first_word_flag_oe && !first_word_flag)
		else $error("flag not low after select");
	tied_flag_a: assert property ($fell(cs_n) && strobes_tied |=> first_word_flag_oe)
		else $error("flag not driven on tied read");
	word_step_a: assert property ($changed(parallel_data_bus) |-> !$past(rd_n) && !$past(cs_n))
		else $error("word changed without a read");
	first_read_a: assert property ($rose(first_word_flag) |-> !$past(rd_n))
		else $error("flag rose without a read");
endmodule : adc_seq_monitor
bind adc_convert_read_wake_seq adc_seq_monitor #(.CONV_UNIT_CYC(CONV_UNIT_CYC)) adc_seq_monitor_inst (
	.ref_clk(ref_clk), .nrst(nrst), .convert_start_a(convert_start_a),
	.convert_start_b(convert_start_b), .strobes_tied(strobes_tied), .cs_n(cs_n), .rd_n(rd_n),
	.busy(busy), .parallel_data_bus(parallel_data_bus),
	.parallel_data_bus_oe(parallel_data_bus_oe), .first_word_flag(first_word_flag),
	.first_word_flag_oe(first_word_flag_oe));
`default_nettype wire

//--- sim/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host controller: wake, convert starts and parallel reads
module host_model
	import adc_seq_pkg::*;
#(
	parameter int WAKE_CYC = 20 // Short stand-in for the long wake wait
) (
	input  wire logic              ref_clk,           // Clock
	input  wire logic              busy,              // Busy
	input  wire logic [WORD_W-1:0] bus,               // Data bus
	input  wire logic              bus_oe,            // Bus enable
	input  wire logic              flag,              // First-word flag
	output var logic               standby_control_n, // Wake control
	output var logic               reset_pulse,       // Reset pulse
	output var logic               convert_start_a,   // Start a
	output var logic               convert_start_b,   // Start b
	output var logic               cs_n,              // Select
	output var logic               rd_n,              // Read
	output var logic               strobes_tied       // Tied strobes
);
	logic [17:0] got[$]; // Sampled {enable, flag, word}
	initial begin
		{standby_control_n, reset_pulse, convert_start_a, convert_start_b} = 4'h0;
		{cs_n, rd_n, strobes_tied} = 3'h6;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	// Leave shutdown, pulse reset, let the part settle
	task automatic wake();
		standby_control_n = 1'b1;
		cyc(WAKE_CYC);
		reset_pulse = 1'b1;
		cyc(3);
		reset_pulse = 1'b0;
		cyc(SETTLE_CYC + 2);
	endtask : wake
	// Starts gap cycles apart, then time the busy pulse
	task automatic start(input logic bf, input int gap, output logic early, output int len);
		convert_start_a = !bf;
		convert_start_b = bf;
		cyc(gap);
		early = busy;
		convert_start_a = 1'b1;
		convert_start_b = 1'b1;
		for (len = 0; !busy && len < 4; len++) cyc(1);
		for (len = 0; busy && len < 4000; len++) cyc(1);
		convert_start_a = 1'b0;
		convert_start_b = 1'b0;
		cyc(8);
	endtask : start
	// Read n words; tied strobes fall and rise together
	task automatic read(input logic tied, input int n);
		strobes_tied = tied;
		cs_n = tied;
		cyc(2);
		repeat (n) begin
			rd_n = 1'b0;
			cs_n = 1'b0;
			cyc(2);
			got.push_back({bus_oe, flag, bus});
			rd_n = 1'b1;
			cs_n = tied;
			cyc(2);
		end
		cs_n = 1'b1;
		cyc(2);
	endtask : read
endmodule : host_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// Conversions at every ratio, both read styles, buffer fill and abort
module testbench;
	import adc_seq_pkg::*;
	localparam int UNIT = 2; // Short microsecond keeps the run brief
	logic                     ref_clk = 1'b0;
	logic                     nrst = 1'b0;
	logic [2:0]               os_ratio = 3'h0;
	logic [NUM_CH*WORD_W-1:0] channel_words = '0;
	logic                     sb_n, rst_p, cva, cvb, tied, cs_n, rd_n, busy, boe, flag, foe;
	logic [WORD_W-1:0]        bus, lastw;
	logic [16:0]              exp_q[$];
	logic [15:0]              seed = 16'h0023;
	logic                     e;
	int                       len, num_errors, checked;
	always #10 ref_clk = ~ref_clk;
	adc_convert_read_wake_seq #(.CONV_UNIT_CYC(UNIT)) adc_convert_read_wake_seq_inst (
		.ref_clk(ref_clk), .nrst(nrst), .standby_control_n(sb_n), .reset_pulse(rst_p),
		.os_ratio(os_ratio), .convert_start_a(cva), .convert_start_b(cvb),
		.strobes_tied(tied), .cs_n(cs_n), .rd_n(rd_n), .channel_words(channel_words),
		.busy(busy), .parallel_data_bus(bus), .parallel_data_bus_oe(boe),
		.first_word_flag(flag), .first_word_flag_oe(foe));
	host_model host_model_inst (
		.ref_clk(ref_clk), .busy(busy), .bus(bus), .bus_oe(boe), .flag(flag),
		.standby_control_n(sb_n), .reset_pulse(rst_p), .convert_start_a(cva),
		.convert_start_b(cvb), .cs_n(cs_n), .rd_n(rd_n), .strobes_tied(tied));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(input logic [17:0] seen, input logic [17:0] want);
		checked++;
		if (seen !== want) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic results();
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	// One conversion of fresh words; the model queues its six results
	task automatic convert(input logic [2:0] code, input logic bf);
		int c;
		c = (code > 3'h6) ? 6 : int'(code);
		os_ratio = code;
		for (int i = 0; i < NUM_CH; i++) begin
			seed = lfsr(seed);
			channel_words[i*WORD_W +: WORD_W] = seed;
			exp_q.push_back({i == 0, seed});
		end
		host_model_inst.start(bf, 3, e, len);
		check(18'(e), 18'h0);
		check(18'(len), 18'(((1 << (c + 2)) - 1) * UNIT));
	endtask : convert
	// Read n words; an empty model means a refused read
	task automatic read(input logic t, input int n);
		logic [17:0] w;
		host_model_inst.read(t, n);
		repeat (n) begin
			w = host_model_inst.got.pop_front();
			if (exp_q.size() > 0)
				check(w, {1'b1, exp_q.pop_front()});
			else
				check(w, {2'h2, lastw});
			lastw = w[15:0];
		end
	endtask : read
	initial begin
		host_model_inst.cyc(5);
		nrst = 1'b1;
		host_model_inst.cyc(3);
		check(18'({busy, boe, foe}), 18'h0);
		host_model_inst.wake();
		// Every ratio code, alternating start order and read style
		for (int k = 0; k < 8; k++) begin
			convert(3'(k), k[0]);
			read(k[1], NUM_CH);
		end
		// Overfill the buffer, drain it, then read once from empty
		repeat (3) convert(3'h0, 1'b0);
		read(1'b0, 3 * NUM_CH + 1);
		// Reset pulse mid-conversion drops the conversion and buffered words
		convert(3'h0, 1'b1);
		os_ratio = 3'h6;
		fork
			host_model_inst.start(1'b0, 3, e, len);
			begin
				host_model_inst.cyc(30);
				host_model_inst.wake();
			end
		join
		// Busy ran from the start edge until the reset pulse, 30 + 20 - 3 cycles
		check(18'(len), 18'(30 + 20 - 3));
		// Starts inside the settle time after a host reset are dropped, not queued
		fork
			host_model_inst.wake();
			begin
				host_model_inst.cyc(60);
				host_model_inst.start(1'b1, 3, e, len);
			end
		join
		check(18'(e), 18'h0);
		check(18'(len), 18'h0);
		exp_q.delete();
		convert(3'h1, 1'b0);
		read(1'b1, NUM_CH);
		results();
	end
	// Watchdog well above the expected run length
	initial begin
		#(20 * 40000);
		num_errors++;
		results();
	end
endmodule : testbench
`default_nettype wire
